// *** common/lrc_consts.vh ***
// constants for the lfsr random number and crc16 unit
`ifndef LRC_CONSTS_VH
`define LRC_CONSTS_VH

// register indexes; byte address is four times the index
`define LRC_IDX_LOW        8'hbc
`define LRC_IDX_HIGH       8'hbd
`define LRC_IDX_CTRL       8'hbe
`define LRC_ADDR_W         10
`define LRC_DATA_W         32

// lfsr layout
`define LRC_LFSR_W         16
`define LRC_LFSR_RESET     16'hffff
`define LRC_POLY           16'h8005
`define LRC_BYTE_W         8

// unrolling depths
`define LRC_RND_STEPS      13
`define LRC_CRC_STEPS      8

// generator control field
`define LRC_CTRL_W         2
`define LRC_CTRL_RUN       2'h0
`define LRC_CTRL_STEP      2'h1
`define LRC_CTRL_OFF       2'h3
`define LRC_CTRL_RESET     2'h0

`endif

// *** hw/lrc_unroll.v ***
// combinational lfsr stepping network: single, crc byte and random unrolled
`timescale 1ns/1ps
`include "lrc_consts.vh"

module lrc_unroll (
  input  wire [`LRC_LFSR_W-1:0] state_in,
  input  wire [`LRC_BYTE_W-1:0] data_in,
  output reg  [`LRC_LFSR_W-1:0] single_out,
  output reg  [`LRC_LFSR_W-1:0] crc_out,
  output reg  [`LRC_LFSR_W-1:0] random_out
);

  // one shift of the x^16 + x^15 + x^2 + 1 register with one input bit
  function [`LRC_LFSR_W-1:0] lrc_step;
    input [`LRC_LFSR_W-1:0] s;
    input                   din;
    reg                     fb;
    begin
      fb = s[`LRC_LFSR_W-1] ^ din;
      lrc_step = {s[`LRC_LFSR_W-2:0], 1'b0} ^ (fb ? `LRC_POLY : {`LRC_LFSR_W{1'b0}});
    end
  endfunction

  integer i;

  always @* begin
    single_out = lrc_step(state_in, 1'b0);
    // msb of the written byte enters first
    crc_out = state_in;
    for (i = `LRC_BYTE_W - 1; i >= 0; i = i - 1) begin
      crc_out = lrc_step(crc_out, data_in[i]);
    end
    random_out = state_in;
    for (i = 0; i < `LRC_RND_STEPS; i = i + 1) begin
      random_out = lrc_step(random_out, 1'b0);
    end
  end

endmodule

// *** hw/lrc_top.v ***
// lfsr random byte source and crc16 unit with avalon-mm register slave
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "lrc_consts.vh"

// Summary of operation
// - state is a 16-bit lfsr with polynomial x^16 + x^15 + x^2 + 1.
// - control field value 11 switches the generator off.
// - control 00: each sequencer read in a clock without a low or high port write advances the register thirteen steps.
// - random bytes reach both cpu reads and the strobe sequencer.
// - low port write shifts low byte up and loads written byte low unless control is 11.
// - a high port write starts a crc16 update with that byte unless control is 11.
// - crc takes the byte msb first, eight steps in one clock.
// - the 16-bit state is readable as two byte ports.
// - control 01 gives one single step unless a low or high port write comes in that clock, then the field clears to 00.
// - after reset the register holds all ones.
// - high port reads upper byte, low port reads lower byte.
module lrc_top (
  input  wire                     mclk_in,
  input  wire                     reset_in,
  input  wire [`LRC_ADDR_W-1:0]   avs_address_in,
  input  wire                     avs_read_in,
  input  wire                     avs_write_in,
  input  wire [`LRC_DATA_W-1:0]   avs_writedata_in,
  input  wire [3:0]               avs_byteenable_in,
  output wire [`LRC_DATA_W-1:0]   avs_readdata_out,
  output wire                     avs_waitrequest_out,
  input  wire                     seq_rnd_read_in,
  output wire [`LRC_BYTE_W-1:0]   seq_rnd_byte_out
);

  reg  [`LRC_LFSR_W-1:0] lfsr_reg;
  reg  [`LRC_LFSR_W-1:0] lfsr_next;
  reg  [`LRC_CTRL_W-1:0] generator_control_field_reg;
  reg  [`LRC_CTRL_W-1:0] generator_control_field_next;
  reg  [`LRC_DATA_W-1:0] rdata_reg;
  reg  [`LRC_DATA_W-1:0] rdata_next;
  reg  [`LRC_DATA_W-1:0] rd_value;

  // read handshake states, one-hot
  localparam RD_STATE_W = 2;
  localparam [RD_STATE_W-1:0] RD_IDLE   = 2'h1;
  localparam [RD_STATE_W-1:0] RD_ANSWER = 2'h2;

  reg  [RD_STATE_W-1:0]  rd_state_reg;
  reg  [RD_STATE_W-1:0]  rd_state_next;
  wire                   rd_capture;

  wire [`LRC_LFSR_W-1:0] lfsr_single;
  wire [`LRC_LFSR_W-1:0] lfsr_crc;
  wire [`LRC_LFSR_W-1:0] lfsr_random;

  wire                   wr_low;
  wire                   wr_high;
  wire                   wr_ctrl;
  wire                   gen_off;
  wire                   ctrl_run;
  wire                   ctrl_step;

  wire                   hit_low;
  wire                   hit_high;
  wire                   hit_ctrl;
  wire                   wr_enabled;

  wire [`LRC_BYTE_W-1:0] wr_byte;
  wire [`LRC_BYTE_W-1:0] lfsr_low_byte;
  wire [`LRC_BYTE_W-1:0] lfsr_high_byte;

  wire                   upd_seed;
  wire                   upd_crc;
  wire                   upd_step;
  wire                   upd_seq;

  // byte address of a register index
  function [`LRC_ADDR_W-1:0] lrc_addr;
    input [7:0] idx;
    begin
      lrc_addr = {idx, 2'b00};
    end
  endfunction

  // address matches a register; byte lanes are not looked at
  function lrc_hit;
    input [`LRC_ADDR_W-1:0] addr;
    input [7:0]             idx;
    begin
      lrc_hit = (addr == lrc_addr(idx));
    end
  endfunction

  lrc_unroll u_unroll (
    .state_in   (lfsr_reg),
    .data_in    (avs_writedata_in[`LRC_BYTE_W-1:0]),
    .single_out (lfsr_single),
    .crc_out    (lfsr_crc),
    .random_out (lfsr_random)
  );

  // register decode, shared by reads and writes
  assign hit_low    = lrc_hit(avs_address_in, `LRC_IDX_LOW);
  assign hit_high   = lrc_hit(avs_address_in, `LRC_IDX_HIGH);
  assign hit_ctrl   = lrc_hit(avs_address_in, `LRC_IDX_CTRL);
  // a write with the low byte lane off is ignored
  assign wr_enabled = avs_write_in & avs_byteenable_in[0];

  assign wr_low  = wr_enabled & hit_low;
  assign wr_high = wr_enabled & hit_high;
  assign wr_ctrl = wr_enabled & hit_ctrl;

  assign wr_byte        = avs_writedata_in[`LRC_BYTE_W-1:0];
  assign lfsr_low_byte  = lfsr_reg[`LRC_BYTE_W-1:0];
  assign lfsr_high_byte = lfsr_reg[`LRC_LFSR_W-1:`LRC_BYTE_W];

  assign gen_off = (generator_control_field_reg == `LRC_CTRL_OFF);
  assign ctrl_run  = (generator_control_field_reg == `LRC_CTRL_RUN);
  assign ctrl_step = (generator_control_field_reg == `LRC_CTRL_STEP);

  // one update per clock: low write, high write, single step, sequencer
  assign upd_seed = ~gen_off & wr_low;
  assign upd_crc  = ~gen_off & ~wr_low & wr_high;
  assign upd_step = ~gen_off & ~wr_low & ~wr_high & ctrl_step;
  assign upd_seq  = ~gen_off & ~wr_low & ~wr_high & ~ctrl_step & ctrl_run & seq_rnd_read_in;

  // lfsr next state; at most one update source is active
  always @* begin
    lfsr_next = lfsr_reg;
    if (upd_seed) begin
      lfsr_next = {lfsr_low_byte, wr_byte};
    end else if (upd_crc) begin
      lfsr_next = lfsr_crc;
    end else if (upd_step) begin
      lfsr_next = lfsr_single;
    end else if (upd_seq) begin
      lfsr_next = lfsr_random;
    end
  end

  // control field next value
  always @* begin
    generator_control_field_next = generator_control_field_reg;
    if (wr_ctrl) begin
      // a fresh write wins over the automatic clear
      generator_control_field_next = avs_writedata_in[`LRC_CTRL_W-1:0];
    end else if (ctrl_step) begin
      generator_control_field_next = `LRC_CTRL_RUN;
    end
  end

  always @* begin
    rd_value = {`LRC_DATA_W{1'b0}};
    if (hit_low) begin
      rd_value[`LRC_BYTE_W-1:0] = lfsr_low_byte;
    end else if (hit_high) begin
      rd_value[`LRC_BYTE_W-1:0] = lfsr_high_byte;
    end else if (hit_ctrl) begin
      rd_value[`LRC_CTRL_W-1:0] = generator_control_field_reg;
    end
  end

  always @* begin
    rdata_next = rdata_reg;
    if (rd_capture) begin
      rdata_next = rd_value;
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      lfsr_reg <= `LRC_LFSR_RESET;
      generator_control_field_reg <= `LRC_CTRL_RESET;
    end else begin
      lfsr_reg <= lfsr_next;
      generator_control_field_reg <= generator_control_field_next;
    end
  end

  // read answer: one wait cycle so that read data come from a flop
  always @* begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (avs_read_in) begin
          rd_state_next = RD_ANSWER;
        end
      end
      RD_ANSWER: begin
        // data stand this cycle; a read still held starts over next cycle
        rd_state_next = RD_IDLE;
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
  end

  // capture in the first cycle of a read, answer in the second
  assign rd_capture = avs_read_in & (rd_state_reg == RD_IDLE);

  always @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_reg    <= {`LRC_DATA_W{1'b0}};
      rd_state_reg <= RD_IDLE;
    end else begin
      rdata_reg    <= rdata_next;
      rd_state_reg <= rd_state_next;
    end
  end

  assign avs_waitrequest_out = rd_capture;
  assign avs_readdata_out    = rdata_reg;

  // random byte straight to the sequencer
  assign seq_rnd_byte_out = lfsr_reg[`LRC_BYTE_W-1:0];

endmodule

// *** verification/lrc_checker.sv ***
// assertion checker for the lfsr random and crc unit
`timescale 1ns/1ps
`include "lrc_consts.vh"
module lrc_checker (
  input wire                   mclk_in,
  input wire                   reset_in,
  input wire [`LRC_ADDR_W-1:0] avs_address_in,
  input wire                   avs_read_in,
  input wire                   avs_write_in,
  input wire [`LRC_DATA_W-1:0] avs_writedata_in,
  input wire [3:0]             avs_byteenable_in,
  input wire [`LRC_DATA_W-1:0] avs_readdata_out,
  input wire                   avs_waitrequest_out,
  input wire                   seq_rnd_read_in,
  input wire [`LRC_BYTE_W-1:0] seq_rnd_byte_out
);
  wire       wr_ok = avs_write_in && avs_byteenable_in[0];
  wire       ctl_wr = wr_ok && avs_address_in == 10'h2f8;
  wire       mapped = avs_address_in inside {10'h2f0, 10'h2f4, 10'h2f8};
  wire [7:0] wd8 = avs_writedata_in[7:0];
  reg        off_reg;
  always @(posedge mclk_in) off_reg <= reset_in ? 1'b0 : ctl_wr ? wd8[1:0] == 2'h3 : off_reg;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_rd_start; $rose(avs_read_in); endsequence
  sequence s_rd_end; avs_read_in && !avs_waitrequest_out; endsequence
  a_reset_ones: assert property (disable iff (1'b0) reset_in |=> seq_rnd_byte_out == 8'hff)
    else $error("reset value wrong");
  a_read_wait: assert property (s_rd_start |-> avs_waitrequest_out) else $error("read not stalled");
  a_read_done: assert property (s_rd_start |=> s_rd_end) else $error("read not answered");
  a_write_nowait: assert property (avs_write_in |-> !avs_waitrequest_out) else $error("write stalled");
  a_seed_low: assert property (wr_ok && avs_address_in == 10'h2f0 && !off_reg |=>
    seq_rnd_byte_out == $past(wd8)) else $error("seed byte not loaded");
  a_off_hold: assert property (off_reg && !ctl_wr |=> $stable(seq_rnd_byte_out))
    else $error("moved while off");
  a_read_keep: assert property (avs_read_in && !seq_rnd_read_in && !$past(ctl_wr) |=>
    $stable(seq_rnd_byte_out)) else $error("read moved state");
  a_low_byte: assert property ((s_rd_end and (avs_address_in == 10'h2f0 && $stable(seq_rnd_byte_out))) |->
    avs_readdata_out[7:0] == seq_rnd_byte_out) else $error("low byte read wrong");
  a_unmapped_zero: assert property ((s_rd_end and !mapped) |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind lrc_top lrc_checker i_chk (.mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .seq_rnd_read_in(seq_rnd_read_in),
  .seq_rnd_byte_out(seq_rnd_byte_out));

// *** verification/lrc_seq_model.sv ***
// sequencer strobe source: one-cycle read pulses spaced by a chosen gap
`timescale 1ns/1ps
module lrc_seq_model (
  input  wire       clk_in,
  input  wire       run_in,
  input  wire [1:0] gap_in,
  output wire       strobe_out
);
  reg [1:0] cnt_reg;
  assign strobe_out = run_in && cnt_reg == 2'h0;
  always @(posedge clk_in) cnt_reg <= (!run_in || cnt_reg == 2'h0) ? gap_in : cnt_reg - 2'h1;
endmodule

// *** verification/lrc_top_bench.sv ***
// self-checking bench for the lfsr random and crc unit
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end
module lrc_top_bench;
  reg        mclk_in = 0, reset_in = 1, rd = 0, wr = 0, run = 0;
  reg [9:0]  adr = 10'h0;
  reg [31:0] wd = 32'h0, q, rs = 32'h3637;
  reg [3:0]  be = 4'h1;
  reg [1:0]  gap = 2'h0;
  reg [15:0] e;
  wire [31:0] rdat;
  wire        wreq, stb;
  wire [7:0]  rb;
  int         fail_count = 0, checked = 0, i;
  always #10 mclk_in = ~mclk_in;
  lrc_top i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .seq_rnd_read_in(stb), .seq_rnd_byte_out(rb));
  lrc_seq_model i_seq (.clk_in(mclk_in), .run_in(run), .gap_in(gap), .strobe_out(stb));
  function [31:0] xs(input [31:0] x); x ^= x << 13; x ^= x >> 17; return x ^ (x << 5); endfunction
  function [15:0] st(input [15:0] s, input d); return {s[14:0], 1'b0} ^ ((s[15] ^ d) ? 16'h8005 : 16'h0); endfunction
  function [15:0] crc(input [15:0] s, input [7:0] b);
    for (int k = 7; k >= 0; k--) s = st(s, b[k]);
    return s;
  endfunction
  function [15:0] rnd(input [15:0] s); repeat (13) s = st(s, 1'b0); return s; endfunction
  task conclude; begin
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  // called just after a rising edge; waitrequest and read data are taken at the rising edge;
  // hold keeps a write up for the next one
  task bus(input [9:0] a, input w, input [31:0] d, input hold); int n; begin
    rd <= !w; wr <= w; adr <= a; wd <= d;
    for (n = 0; n < 50; n++) begin @(posedge mclk_in); if (!wreq) begin q = rdat; break; end end
    if (n == 50) begin fail_count++; conclude; end
    if (!hold) begin rd <= 0; wr <= 0; @(posedge mclk_in); end
  end endtask
  task rdb; begin
    bus(10'h2f0, 0, 0, 0); `CHK(q, {24'h0, e[7:0]})
    bus(10'h2f4, 0, 0, 0); `CHK(q, {24'h0, e[15:8]})
  end endtask
  task strobes(input int n); begin
    run <= 1;
    for (i = 0; i < n; i++) begin
      @(negedge mclk_in); `CHK(rb, e[7:0])
      if (stb && !gap[1]) e = rnd(e);
    end
    @(posedge mclk_in); run <= 0; @(posedge mclk_in);
  end endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    reset_in <= 0; @(posedge mclk_in);
    e = 16'hffff; rdb;
    for (int s = 0; s < 2; s++) begin
      repeat (2) begin rs = xs(rs); bus(10'h2f0, 1, rs, 0); e = {e[7:0], rs[7:0]}; end
      rdb;
      repeat (2) bus(10'h2f0, 1, s ? 32'hff : 32'h0, 0);
      e = s ? 16'hffff : 16'h0;
      for (i = 0; i < 8; i++) begin rs = xs(rs); bus(10'h2f4, 1, rs, 1); e = crc(e, rs[7:0]); end
      wr <= 0; @(posedge mclk_in); rdb;
    end
    $display("test seed crc done");
    bus(10'h2f8, 1, 1, 0); e = st(e, 1'b0); rdb;
    bus(10'h2f8, 0, 0, 0); `CHK(q[1:0], 2'h0)
    repeat (4) begin rs = xs(rs); gap <= {1'b0, rs[0]}; @(posedge mclk_in); strobes(30); rdb; end
    bus(10'h2f8, 1, 3, 0); gap <= 2'h2; strobes(10);
    bus(10'h2f0, 1, 8'h5a, 0); bus(10'h2f4, 1, 8'ha5, 0); rdb;
    bus(10'h2f8, 0, 0, 0); `CHK(q[1:0], 2'h3)
    bus(10'h2f8, 1, 0, 0); be <= 4'h0; bus(10'h2f0, 1, 8'h3c, 0); be <= 4'h1;
    bus(10'h2fc, 1, 8'h3c, 0); bus(10'h2fc, 0, 0, 0); `CHK(q, 32'h0)
    rdb;
    $display("test control done");
    conclude;
  end
endmodule
